// ===== pssw_top.sv
`timescale 1ns/1ps
`include "pssw_defines.svh"
// What this block does
// RL1: Sleep method 0 sleeps only on terminal, 1 by frequency, 2 by deviation.
// RL2: Frequency sleep needs run frequency at or below the start level too long.
// RL3: Deviation sleep, positive output, needs feedback above reference by more.
// RL4: Deviation sleep, negative output, needs feedback below reference by more.
// RL5: A qualified sleep boosts the reference for the boost time, then sleeps.
// RL6: When the set boost time runs out the drive sleeps at once.
// RL7: With positive output wakeup needs feedback below reference by more.
// RL8: With negative output wakeup needs feedback above reference by more.
// RL9: The wake delay is the least time the wake condition must persist.
// RL10: On wakeup the wake frequency is commanded, then regulation resumes.
// RL11: A qualification timer restarts from zero when its condition lapses.
module pssw_top #(
  parameter int unsigned TICK_CYCLES =
    `PSSW_TICK_PERIOD_NS / `PSSW_CLK_PERIOD_NS
) (
  input  wire logic        REF_CLK,     // 100 MHz control clock
  input  wire logic        RST_N,       // Async reset, low
  input  wire logic        CE,          // Clock enable
  input  wire logic        HSEL,        // AHB select
  input  wire logic [31:0] HADDR,       // AHB address
  input  wire logic [1:0]  HTRANS,      // AHB transfer type
  input  wire logic        HWRITE,      // AHB write
  input  wire logic [2:0]  HSIZE,       // AHB size, word only
  input  wire logic [31:0] HWDATA,      // AHB write data
  input  wire logic        HREADY,      // AHB bus ready
  output logic [31:0]      HRDATA,      // AHB read data
  output logic             HREADYOUT,   // AHB slave ready
  output logic             HRESP,       // AHB response, OKAY
  input  wire logic [15:0] RUN_FREQ,    // Running freq, 0.01 Hz
  input  wire logic [15:0] FEEDBACK,    // Regulator feedback, 0.1 %
  input  wire logic [15:0] REFERENCE,   // Regulator reference, 0.1 %
  input  wire logic        OUTPUT_NEG,  // Regulator output negative
  input  wire logic        TERM_SLEEP,  // Sleep terminal pin
  output logic [15:0]      REF_OUT,     // Reference to the regulator
  output logic             BOOST_ACTIVE,// Reference boost in force
  output logic             SLEEPING,    // Drive held asleep
  output logic             FREQ_LOAD,   // Pulse: load FREQ_CMD
  output logic [15:0]      FREQ_CMD     // Wake frequency command
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp_u(input logic [15:0] v,
                                          input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction : clamp_u

  // True when a exceeds b by more than thr
  function automatic logic over_by(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input logic [15:0] thr);
    logic [15:0] d;
    d = a - b;
    return (a > b) && (d > thr);
  endfunction : over_by

  // Reference plus signed boost, held inside 0..FFFF
  function automatic logic [15:0] boost_ref(input logic [15:0] r,
                                            input logic [15:0] b);
    logic signed [17:0] s;
    s = $signed({2'b00, r}) + $signed({{2{b[15]}}, b});
    if (s < 18'sd0) return 16'h0000;
    if (s > 18'sd65535) return 16'hFFFF;
    return s[15:0];
  endfunction : boost_ref

  function automatic logic [15:0] clamp_s(input logic [15:0] v);
    logic signed [15:0] sv;
    sv = $signed(v);
    if (sv > $signed(`PSSW_MAX_BOOST)) return `PSSW_MAX_BOOST;
    if (sv < -$signed(`PSSW_MAX_BOOST)) return -`PSSW_MAX_BOOST;
    return v;
  endfunction : clamp_s

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pssw_pkg::pssw_state_t  state;
  pssw_pkg::pssw_state_t  next_state;
  pssw_pkg::pssw_method_t method;
  logic [15:0] sleep_freq, sleep_dev, sleep_dly, boost_val;
  logic [15:0] boost_time, wake_freq, wake_dev, wake_dly;
  logic        term_s1, term_s2;
  logic        tick;
  logic        sleep_cond, wake_cond, boost_cond;
  logic        sleep_done, wake_done, boost_done;
  logic [7:0]  addr_q;
  logic        addr_ok, wr_pend, rd_pend;
  logic        take;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign take = HSEL && HREADY && HTRANS[1];

  // Address phase capture; reads add one wait state
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_q    <= 8'h00;
      addr_ok   <= 1'b0;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
    end else if (CE) begin
      HRESP <= 1'b0;
      if (rd_pend) begin
        HRDATA    <= rd_mux;
        HREADYOUT <= 1'b1;
        rd_pend   <= 1'b0;
        wr_pend   <= 1'b0;
      end else begin
        addr_q    <= HADDR[7:0];
        addr_ok   <= (HADDR[31:8] == 24'h0) && (HADDR[1:0] == 2'h0);
        wr_pend   <= take && HWRITE;
        rd_pend   <= take && !HWRITE;
        HREADYOUT <= !(take && !HWRITE);
      end
    end
  end

  // Read data select; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok) begin
      case (addr_q)
        `PSSW_OFS_CTRL:       rd_mux = {30'h0, method};
        `PSSW_OFS_SLEEP_FREQ: rd_mux = {16'h0, sleep_freq};
        `PSSW_OFS_SLEEP_DEV:  rd_mux = {16'h0, sleep_dev};
        `PSSW_OFS_SLEEP_DLY:  rd_mux = {16'h0, sleep_dly};
        `PSSW_OFS_BOOST_VAL:  rd_mux = {16'h0, boost_val};
        `PSSW_OFS_BOOST_TIME: rd_mux = {16'h0, boost_time};
        `PSSW_OFS_WAKE_FREQ:  rd_mux = {16'h0, wake_freq};
        `PSSW_OFS_WAKE_DEV:   rd_mux = {16'h0, wake_dev};
        `PSSW_OFS_WAKE_DLY:   rd_mux = {16'h0, wake_dly};
        `PSSW_OFS_STATUS:     rd_mux = {26'h0, wake_cond, sleep_cond,
                                        2'h0, state};
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  // Data phase writes, clamped to the legal ranges
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      method     <= pssw_pkg::pssw_method_t'(`PSSW_RST_METHOD);
      sleep_freq <= `PSSW_RST_SLEEP_FREQ;
      sleep_dev  <= `PSSW_RST_SLEEP_DEV;
      sleep_dly  <= `PSSW_RST_SLEEP_DLY;
      boost_val  <= `PSSW_RST_BOOST_VAL;
      boost_time <= `PSSW_RST_BOOST_TIME;
      wake_freq  <= `PSSW_RST_WAKE_FREQ;
      wake_dev   <= `PSSW_RST_WAKE_DEV;
      wake_dly   <= `PSSW_RST_WAKE_DLY;
    end else if (CE && wr_pend && addr_ok) begin
      case (addr_q)
        `PSSW_OFS_CTRL: begin
          if (HWDATA[1:0] != 2'h3) begin // [RL1]
            method <= pssw_pkg::pssw_method_t'(HWDATA[
              `PSSW_CTRL_METHOD_MSB:`PSSW_CTRL_METHOD_LSB]);
          end
        end
        `PSSW_OFS_SLEEP_FREQ: sleep_freq <= HWDATA[15:0];
        `PSSW_OFS_SLEEP_DEV:
          sleep_dev <= clamp_u(HWDATA[15:0], `PSSW_MAX_DEV);
        `PSSW_OFS_SLEEP_DLY:
          sleep_dly <= clamp_u(HWDATA[15:0], `PSSW_MAX_DLY);
        `PSSW_OFS_BOOST_VAL:  boost_val <= clamp_s(HWDATA[15:0]);
        `PSSW_OFS_BOOST_TIME:
          boost_time <= clamp_u(HWDATA[15:0], `PSSW_MAX_BOOST_TIME);
        `PSSW_OFS_WAKE_FREQ:  wake_freq <= HWDATA[15:0];
        `PSSW_OFS_WAKE_DEV:
          wake_dev <= clamp_u(HWDATA[15:0], `PSSW_MAX_DEV);
        `PSSW_OFS_WAKE_DLY:
          wake_dly <= clamp_u(HWDATA[15:0], `PSSW_MAX_DLY);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Terminal synchroniser and time base
  // ----------------------------------------------------------------
  // Two flops ahead of any use of the pin
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      term_s1 <= 1'b0;
      term_s2 <= 1'b0;
    end else if (CE) begin
      term_s1 <= TERM_SLEEP;
      term_s2 <= term_s1;
    end
  end

  pssw_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Qualification conditions and timers
  // ----------------------------------------------------------------
  // Sleep, boost and wake conditions per method and polarity
  always_comb begin
    sleep_cond = 1'b0;
    if (state == pssw_pkg::ST_RUN) begin
      case (method)
        pssw_pkg::PSSW_BY_FREQ:
          sleep_cond = RUN_FREQ <= sleep_freq; // [RL2]
        pssw_pkg::PSSW_BY_DEV:
          sleep_cond = OUTPUT_NEG
            ? over_by(REFERENCE, FEEDBACK, sleep_dev)  // [RL4]
            : over_by(FEEDBACK, REFERENCE, sleep_dev); // [RL3]
        default: sleep_cond = 1'b0;
      endcase
    end
    wake_cond = (state == pssw_pkg::ST_SLEEP) && (OUTPUT_NEG
      ? over_by(FEEDBACK, REFERENCE, wake_dev)   // [RL8]
      : over_by(REFERENCE, FEEDBACK, wake_dev)); // [RL7]
    boost_cond = state == pssw_pkg::ST_BOOST;
  end

  pssw_qual_timer u_sleep_tmr (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .tick  (tick),
    .cond  (sleep_cond),
    .limit (sleep_dly),
    .done  (sleep_done)
  );

  pssw_qual_timer u_boost_tmr (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .tick  (tick),
    .cond  (boost_cond),
    .limit (boost_time),
    .done  (boost_done)
  );

  pssw_qual_timer u_wake_tmr (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .tick  (tick),
    .cond  (wake_cond),
    .limit (wake_dly),
    .done  (wake_done)
  );

  // ----------------------------------------------------------------
  // Sleep and wake sequence
  // ----------------------------------------------------------------
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      pssw_pkg::ST_RUN: begin
        if (method == pssw_pkg::PSSW_TERMINAL) begin
          if (term_s2) next_state = pssw_pkg::ST_SLEEP; // [RL1]
        end else if (sleep_done) begin
          next_state = pssw_pkg::ST_BOOST; // [RL5]
        end
      end
      pssw_pkg::ST_BOOST:
        if (boost_done) next_state = pssw_pkg::ST_SLEEP; // [RL6]
      pssw_pkg::ST_SLEEP: begin
        if (method == pssw_pkg::PSSW_TERMINAL) begin
          if (!term_s2) next_state = pssw_pkg::ST_WAKE;
        end else if (wake_done) begin
          next_state = pssw_pkg::ST_WAKE; // [RL9]
        end
      end
      pssw_pkg::ST_WAKE: next_state = pssw_pkg::ST_RUN;
      default: next_state = pssw_pkg::ST_RUN;
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) state <= pssw_pkg::ST_RUN;
    else if (CE) state <= next_state;
  end

  // Outputs follow the next state from flops
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REF_OUT      <= 16'h0000;
      BOOST_ACTIVE <= 1'b0;
      SLEEPING     <= 1'b0;
      FREQ_LOAD    <= 1'b0;
      FREQ_CMD     <= 16'h0000;
    end else if (CE) begin
      BOOST_ACTIVE <= next_state == pssw_pkg::ST_BOOST;
      REF_OUT      <= (next_state == pssw_pkg::ST_BOOST)
                      ? boost_ref(REFERENCE, boost_val) // [RL5]
                      : REFERENCE;
      SLEEPING     <= next_state == pssw_pkg::ST_SLEEP;
      FREQ_LOAD    <= next_state == pssw_pkg::ST_WAKE; // [RL10]
      if (next_state == pssw_pkg::ST_WAKE) FREQ_CMD <= wake_freq;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  term_only_a: assert property ( // [RL1]
    CE && state == pssw_pkg::ST_RUN
    && method == pssw_pkg::PSSW_TERMINAL |=> state != pssw_pkg::ST_BOOST)
    else $error("boost entered in terminal method");

  freq_qual_a: assert property ( // [RL2]
    CE && state == pssw_pkg::ST_RUN && method == pssw_pkg::PSSW_BY_FREQ
    ##1 state == pssw_pkg::ST_BOOST |-> $past(RUN_FREQ) <= $past(sleep_freq))
    else $error("frequency sleep without low frequency");

  dev_pos_a: assert property ( // [RL3]
    CE && sleep_done && method == pssw_pkg::PSSW_BY_DEV && !OUTPUT_NEG
    |-> FEEDBACK > REFERENCE && FEEDBACK - REFERENCE > sleep_dev)
    else $error("positive deviation sleep without deviation");

  dev_neg_a: assert property ( // [RL4]
    CE && sleep_done && method == pssw_pkg::PSSW_BY_DEV && OUTPUT_NEG
    |-> REFERENCE > FEEDBACK && REFERENCE - FEEDBACK > sleep_dev)
    else $error("negative deviation sleep without deviation");

  boost_ref_a: assert property ( // [RL5]
    CE && next_state == pssw_pkg::ST_BOOST
    |=> BOOST_ACTIVE && REF_OUT == boost_ref($past(REFERENCE),
                                            $past(boost_val)))
    else $error("reference not boosted");

  boost_end_a: assert property ( // [RL6]
    CE && state == pssw_pkg::ST_BOOST && boost_done
    |=> state == pssw_pkg::ST_SLEEP ##0 SLEEPING && !BOOST_ACTIVE)
    else $error("no sleep at end of boost");

  wake_pos_a: assert property ( // [RL7]
    CE && wake_done && !OUTPUT_NEG
    |-> REFERENCE > FEEDBACK && REFERENCE - FEEDBACK > wake_dev)
    else $error("positive wake without deviation");

  wake_neg_a: assert property ( // [RL8]
    CE && wake_done && OUTPUT_NEG
    |-> FEEDBACK > REFERENCE && FEEDBACK - REFERENCE > wake_dev)
    else $error("negative wake without deviation");

  wake_delay_a: assert property ( // [RL9]
    state == pssw_pkg::ST_SLEEP && method != pssw_pkg::PSSW_TERMINAL
    ##1 state == pssw_pkg::ST_WAKE |-> $past(wake_done))
    else $error("woke before wake delay");

  wake_freq_a: assert property ( // [RL10]
    CE && state == pssw_pkg::ST_SLEEP && next_state == pssw_pkg::ST_WAKE
    |=> FREQ_LOAD && FREQ_CMD == $past(wake_freq) ##1 (!CE || !FREQ_LOAD))
    else $error("wake frequency not commanded");

  read_wait_a: assert property (
    CE && take && !HWRITE ##1 CE |-> !HREADYOUT ##1 HREADYOUT)
    else $error("read answer timing wrong");

  boost_seen_c: cover property (state == pssw_pkg::ST_BOOST);
  sleep_seen_c: cover property (
    state == pssw_pkg::ST_BOOST ##1 state == pssw_pkg::ST_SLEEP);
  wake_seen_c:  cover property (FREQ_LOAD);
  term_seen_c:  cover property (
    method == pssw_pkg::PSSW_TERMINAL && SLEEPING);

endmodule : pssw_top

// ===== pssw_defines.svh
`ifndef PSSW_DEFINES_SVH
`define PSSW_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PSSW_OFS_CTRL        8'h00
`define PSSW_OFS_SLEEP_FREQ  8'h04
`define PSSW_OFS_SLEEP_DEV   8'h08
`define PSSW_OFS_SLEEP_DLY   8'h0C
`define PSSW_OFS_BOOST_VAL   8'h10
`define PSSW_OFS_BOOST_TIME  8'h14
`define PSSW_OFS_WAKE_FREQ   8'h18
`define PSSW_OFS_WAKE_DEV    8'h1C
`define PSSW_OFS_WAKE_DLY    8'h20
`define PSSW_OFS_STATUS      8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSSW_CTRL_METHOD_MSB 1
`define PSSW_CTRL_METHOD_LSB 0

// ----------------------------------------------------------------
// Reset values (0.01 Hz, 0.1 %, 0.1 s units)
// ----------------------------------------------------------------
`define PSSW_RST_METHOD      2'h0
`define PSSW_RST_SLEEP_FREQ  16'h01F4
`define PSSW_RST_SLEEP_DEV   16'h0032
`define PSSW_RST_SLEEP_DLY   16'h0258
`define PSSW_RST_BOOST_VAL   16'h0064
`define PSSW_RST_BOOST_TIME  16'h0064
`define PSSW_RST_WAKE_FREQ   16'h01F4
`define PSSW_RST_WAKE_DEV    16'h0032
`define PSSW_RST_WAKE_DLY    16'h0032

// ----------------------------------------------------------------
// Limits of writable ranges
// ----------------------------------------------------------------
`define PSSW_MAX_DEV         16'h012C
`define PSSW_MAX_DLY         16'h8CA0
`define PSSW_MAX_BOOST       16'h03E8
`define PSSW_MAX_BOOST_TIME  16'hEA60

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSSW_CLK_PERIOD_NS   10
`define PSSW_TICK_PERIOD_NS  100000000

`endif

// ===== pssw_pkg.sv
package pssw_pkg;

  // Sleep method encodings 0, 1, 2
  typedef enum logic [1:0] {
    PSSW_TERMINAL,
    PSSW_BY_FREQ,
    PSSW_BY_DEV
  } pssw_method_t;

  // Controller states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_BOOST,
    ST_SLEEP,
    ST_WAKE
  } pssw_state_t;

endpackage : pssw_pkg

// ===== pssw_tick_gen.sv
`timescale 1ns/1ps
module pssw_tick_gen #(
  parameter int unsigned CYCLES = 10
) (
  input  wire logic clk,    // Control clock
  input  wire logic rst_n,  // Async reset, low
  input  wire logic ce,     // Clock enable
  output logic      tick    // One pulse per 0.1 s
);

  logic [31:0] cnt;

  // Divide the clock down to the 0.1 s time base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else if (ce) begin
      if (cnt >= CYCLES - 32'h1) begin
        cnt  <= 32'h0;
        tick <= 1'b1;
      end else begin
        cnt  <= cnt + 32'h1;
        tick <= 1'b0;
      end
    end
  end

endmodule : pssw_tick_gen

// ===== pssw_qual_timer.sv
`timescale 1ns/1ps
module pssw_qual_timer (
  input  wire logic        clk,    // Control clock
  input  wire logic        rst_n,  // Async reset, low
  input  wire logic        ce,     // Clock enable
  input  wire logic        tick,   // 0.1 s time base
  input  wire logic        cond,   // Condition being qualified
  input  wire logic [15:0] limit,  // Delay in 0.1 s
  output logic             done    // Condition held longer than limit
);

  logic [15:0] cnt;

  // Count ticks while the condition holds, restart when it lapses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
    end else if (ce) begin
      if (!cond) begin
        cnt <= 16'h0000; // [RL11]
      end else if (tick && cnt != 16'hFFFF) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  assign done = cond && (cnt > limit);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  timer_restart_a: assert property ( // [RL11]
    @(posedge clk) disable iff (!rst_n)
    ce && !cond |=> cnt == 16'h0000)
    else $error("timer did not restart on lapse");

endmodule : pssw_qual_timer

// ===== pssw_reg_model.sv
`timescale 1ns/1ps
module pssw_reg_model (
  input  wire logic        clk,        // Control clock
  input  wire logic        rst_n,      // Async reset, low
  input  wire logic        sleeping,   // Drive held asleep
  input  wire logic        freq_load,  // Wake frequency load pulse
  input  wire logic [15:0] freq_cmd,   // Wake frequency value
  input  wire logic        tgt_we,     // New settled speed strobe
  input  wire logic [15:0] tgt,        // Speed the loop settles to
  output logic      [15:0] run_freq    // Running frequency
);
  // ----------------------------------------------------------------
  // Speed path
  // ----------------------------------------------------------------
  // Stopped while asleep, restarts from the wake value, then regulates
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_freq <= 16'h0000;
    end else if (sleeping) begin
      run_freq <= 16'h0000;
    end else if (freq_load) begin
      run_freq <= freq_cmd;
    end else if (tgt_we) begin
      run_freq <= tgt;
    end
  end
endmodule : pssw_reg_model

// ===== pssw_top_tb.sv
`timescale 1ns/1ps
`include "pssw_defines.svh"
module pssw_top_tb;
  localparam int unsigned TCK = 10;
  logic        ref_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] run_freq;
  logic [15:0] feedback;
  logic [15:0] refv;
  logic        output_neg;
  logic        term_sleep;
  logic [15:0] ref_out;
  logic        boost_active;
  logic        sleeping;
  logic        freq_load;
  logic [15:0] freq_cmd;
  logic        tgt_we;
  logic [15:0] tgt;
  logic [31:0] rd;
  logic [15:0] defs [9];
  int          cyc;
  int          error_cnt;
  int          n_checks;

  pssw_top #(.TICK_CYCLES(TCK)) i_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'b1), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .RUN_FREQ(run_freq),
    .FEEDBACK(feedback), .REFERENCE(refv), .OUTPUT_NEG(output_neg),
    .TERM_SLEEP(term_sleep), .REF_OUT(ref_out),
    .BOOST_ACTIVE(boost_active), .SLEEPING(sleeping),
    .FREQ_LOAD(freq_load), .FREQ_CMD(freq_cmd));

  pssw_reg_model i_model (
    .clk(ref_clk), .rst_n(rst_n), .sleeping(sleeping),
    .freq_load(freq_load), .freq_cmd(freq_cmd), .tgt_we(tgt_we),
    .tgt(tgt), .run_freq(run_freq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic inw(input int lo, input int hi);
    n_checks++;
    if (cyc < lo || cyc > hi) begin
      error_cnt++;
      $display("MISMATCH t=%0t wait took %0d cycles", $time, cyc);
    end
  endtask : inw

  // One AHB transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h00000000;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask : bus

  task automatic setf(input logic [15:0] v);
    tgt    <= v;
    tgt_we <= 1'b1;
    @(posedge ref_clk);
    tgt_we <= 1'b0;
  endtask : setf

  // Waits for boost (0), sleep (1) or wake load (2), counting cycles
  task automatic wt(input int sel);
    logic s;
    cyc = 0;
    s = 1'b0;
    while (s !== 1'b1 && cyc < 2000) begin
      @(posedge ref_clk);
      cyc++;
      case (sel)
        0: s = boost_active;
        1: s = sleeping;
        default: s = freq_load;
      endcase
    end
    inw(1, 1999);
  endtask : wt

  task automatic sleep_wake(input logic neg, input logic [15:0] fs,
                            input logic [15:0] fw, input logic [15:0] bx);
    output_neg <= neg;
    feedback   <= fs;
    wt(0);
    inw(30, 45);
    chk(ref_out, bx);
    wt(1);
    inw(20, 35);
    chk(ref_out, 16'h01F4);
    chk(boost_active, 1'b0);
    feedback <= fw;
    wt(2);
    inw(20, 35);
    chk(freq_cmd, 16'h0300);
    feedback <= 16'h01F4;
    @(posedge ref_clk);
    chk(run_freq, 16'h0300);
  endtask : sleep_wake

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #50000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0; feedback = 16'h01F4;
    refv = 16'h01F4;
    output_neg = 1'b0; term_sleep = 1'b0; tgt_we = 1'b0; tgt = 16'h0;
    error_cnt = 0; n_checks = 0;
    defs = '{16'(`PSSW_RST_METHOD), `PSSW_RST_SLEEP_FREQ,
             `PSSW_RST_SLEEP_DEV, `PSSW_RST_SLEEP_DLY, `PSSW_RST_BOOST_VAL,
             `PSSW_RST_BOOST_TIME, `PSSW_RST_WAKE_FREQ, `PSSW_RST_WAKE_DEV,
             `PSSW_RST_WAKE_DLY};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    setf(16'h0400);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rd, {16'h0000, defs[i]});
    end
    chk(hresp, 1'b0);
    // Unmapped place, clamped deviation, refused method code
    bus(1'b1, 8'h40, 32'h00001234);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `PSSW_OFS_SLEEP_DEV, 32'h00000FFF);
    bus(1'b0, `PSSW_OFS_SLEEP_DEV, 32'h0);
    chk(rd, 32'h0000012C);
    bus(1'b1, `PSSW_OFS_SLEEP_DEV, 32'h00000032);
    bus(1'b1, `PSSW_OFS_CTRL, 32'h1);
    bus(1'b1, `PSSW_OFS_CTRL, 32'h3);
    bus(1'b0, `PSSW_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, `PSSW_OFS_SLEEP_DLY, 32'h3);
    bus(1'b1, `PSSW_OFS_BOOST_TIME, 32'h2);
    bus(1'b1, `PSSW_OFS_WAKE_DLY, 32'h2);
    bus(1'b1, `PSSW_OFS_WAKE_FREQ, 32'h300);
    // Frequency sleep with short lapses and the pin ignored
    term_sleep <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      setf(16'h01F4);
      repeat (25) @(posedge ref_clk);
      setf(16'h01F5);
      repeat (3) @(posedge ref_clk);
    end
    chk(boost_active, 1'b0);
    chk(sleeping, 1'b0);
    term_sleep <= 1'b0;
    setf(16'h01F4);
    sleep_wake(1'b0, 16'h01F4, 16'h01C1, 16'h0258);
    // Deviation sleep, boundary first, then both output signs
    bus(1'b1, `PSSW_OFS_BOOST_VAL, 32'h0000FFF6);
    bus(1'b1, `PSSW_OFS_CTRL, 32'h2);
    feedback <= 16'h0226;
    repeat (60) @(posedge ref_clk);
    chk(boost_active, 1'b0);
    // Same boundary with a moved reference
    refv     <= 16'h0258;
    feedback <= 16'h028A;
    repeat (60) @(posedge ref_clk);
    chk(boost_active, 1'b0);
    chk(ref_out, 16'h0258);
    refv     <= 16'h01F4;
    sleep_wake(1'b0, 16'h0227, 16'h01C1, 16'h01EA);
    sleep_wake(1'b1, 16'h01C1, 16'h0227, 16'h01EA);
    // Terminal sleep without boost
    bus(1'b1, `PSSW_OFS_CTRL, 32'h0);
    term_sleep <= 1'b1;
    wt(1);
    chk(ref_out, 16'h01F4);
    bus(1'b0, `PSSW_OFS_STATUS, 32'h0);
    chk(rd, 32'h00000002);
    term_sleep <= 1'b0;
    wt(2);
    chk(freq_cmd, 16'h0300);
    stop_test();
  end
endmodule : pssw_top_tb
